// [core/ccwd_defs.svh]
// Constants for the converter command word decoder
`ifndef CCWD_DEFS_SVH
`define CCWD_DEFS_SVH
`define CCWD_WORD_W     16
`define CCWD_PD_W       16
`define CCWD_SEL_W      3
`define CCWD_NFUNC      4
`define CCWD_B_SWON     0
`define CCWD_B_BRK      1
`define CCWD_B_QSTOP    2
`define CCWD_B_START    3
`define CCWD_B_PRECHG   4
`define CCWD_B_RES5     5
`define CCWD_B_RES6     6
`define CCWD_B_EVRST    7
`define CCWD_B_RES8     8
`define CCWD_B_RES9     9
`define CCWD_B_DVALID   10
`define CCWD_B_WDOG     11
`define CCWD_B_DIN_LO   12
`define CCWD_B_DIN_HI   15
`define CCWD_S_FBCTL    9
`define CCWD_S_WDOG     15
`define CCWD_CMD_RST    16'h0000
`define CCWD_PD_RST     16'h0000
`define CCWD_STAT_RST   16'h0000
`define CCWD_SEL_NONE   3'h0
`endif

// [core/ccwd_pkg.sv]
// Types for the converter command word decoder
`default_nettype none
`include "ccwd_defs.svh"
package ccwd_pkg;
  typedef enum logic [3:0] {
    CCWD_IDLE   = 4'h1,
    CCWD_PRECHG = 4'h2,
    CCWD_CLOSE  = 4'h4,
    CCWD_RUN    = 4'h8
  } ccwd_seq_t;

  typedef struct packed {
    logic precharge_req;
    logic breaker_close_permit;
    logic breaker_close_req;
    logic breaker_open_req;
    logic run_req;
    logic quick_stop_act;
    logic event_reset;
  } ccwd_ctl_t;

  typedef struct packed {
    logic [`CCWD_WORD_W-1:0] cmd;
    logic [`CCWD_PD_W-1:0]   pd;
    ccwd_seq_t               seq;
    ccwd_ctl_t               ctl;
    logic [`CCWD_WORD_W-1:0] status;
  } ccwd_state_t;
endpackage : ccwd_pkg
`default_nettype wire

// [core/ccwd_src_sel.sv]
// Activation source selector for one function input
`timescale 1ns/1ps
`default_nettype none
`include "ccwd_defs.svh"
module ccwd_src_sel (
  // Remote inputs
  input  wire logic [3:0]             din,
  // Source code: 0 none, 1..4 remote input 1..4
  input  wire logic [`CCWD_SEL_W-1:0] sel,
  // Activation
  output logic                        act
);
  always_comb begin
    act = 1'b0;
    if (sel != `CCWD_SEL_NONE && sel <= 3'h4) begin
      act = din[2'(sel - 3'h1)];
    end
  end
endmodule : ccwd_src_sel
`default_nettype wire

// [core/ccwd_decoder.sv]
// Converter command word decoder top
`timescale 1ns/1ps
`default_nettype none
`include "ccwd_defs.svh"
// Functional notes
// - Bit0 low blocks precharge, close, run; opens breaker
// - Bit1 low blocks breaker close and running
// - Bit2 low activates quick stop
// - Bit3 low stops unit or aborts startup
// - Bit3 high: precharge, close breaker, then run; without ownership go straight to run
// - Bit4 starts or stops DC-link precharge
// - Bit7 high clears warnings and faults
// - Bit10 low keeps last valid process data
// - Bit10 high accepts new process data
// - Bits 0-4 and 7 honoured only under fieldbus control place; bits 10-15 act regardless
// - Bit11 echoed to status watchdog feedback
// - Bits12-15 are selectable remote digital inputs
// - Precharge and breaker effects need converter ownership
// - Status bit15 reports received watchdog level
// - Status bit9 shows fieldbus control place
module ccwd_decoder
  import ccwd_pkg::*;
#(
  parameter int NFUNC = `CCWD_NFUNC
) (
  // Clock, reset, enable
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  // Process data from the fieldbus controller
  input  wire logic                          cmd_wr,
  input  wire logic [`CCWD_WORD_W-1:0]       cmd_word,
  input  wire logic [`CCWD_PD_W-1:0]         pd_in,
  // Configuration and converter feedback
  input  wire logic                          remote_control_place_flag,
  input  wire logic                          gcu_owns_breaker,
  input  wire logic                          precharge_done,
  input  wire logic                          breaker_closed,
  input  wire logic [NFUNC*`CCWD_SEL_W-1:0]  func_src_sel,
  // Commands to the sequencing logic
  output ccwd_ctl_t                          ctl,
  output logic [`CCWD_PD_W-1:0]              pd_out,
  output logic [`CCWD_WORD_W-1:0]            status_word,
  output logic [3:0]                         remote_din,
  output logic [NFUNC-1:0]                   func_act
);
  ccwd_state_t r_q;
  ccwd_state_t r_d;
  logic        fb;
  logic        own;
  logic        b_swon;
  logic        b_brk;
  logic        b_qs_n;
  logic        b_start;
  logic        b_pre;
  logic        start_ok;

  assign fb       = remote_control_place_flag;
  assign own      = gcu_owns_breaker;
  assign b_swon   = r_q.cmd[`CCWD_B_SWON];
  assign b_brk    = r_q.cmd[`CCWD_B_BRK];
  assign b_qs_n   = r_q.cmd[`CCWD_B_QSTOP];
  assign b_start  = r_q.cmd[`CCWD_B_START];
  assign b_pre    = r_q.cmd[`CCWD_B_PRECHG];
  assign start_ok = fb && b_swon && b_qs_n && b_start;

  always_comb begin
    r_d = r_q;
    if (cmd_wr) begin
      r_d.cmd = cmd_word;
      if (cmd_word[`CCWD_B_DVALID]) begin
        r_d.pd = pd_in;
      end
    end
    // Without bit10 the held process data stays untouched
    if (!start_ok) begin
      r_d.seq = CCWD_IDLE;
    end else begin
      unique case (r_q.seq)
        CCWD_IDLE: begin
          if (own) begin
            r_d.seq = CCWD_PRECHG;
          end else if (b_brk) begin
            r_d.seq = CCWD_RUN;
          end
        end
        CCWD_PRECHG: begin
          if (precharge_done && b_brk) begin
            r_d.seq = CCWD_CLOSE;
          end
        end
        CCWD_CLOSE: begin
          if (!b_brk) begin
            r_d.seq = CCWD_PRECHG;
          end else if (breaker_closed) begin
            r_d.seq = CCWD_RUN;
          end
        end
        CCWD_RUN: begin
          if (!b_brk) begin
            r_d.seq = CCWD_IDLE;
          end
        end
        default: r_d.seq = CCWD_IDLE;
      endcase
    end
    // Bits 5, 6, 8 and 9 take no part in the decode
    r_d.ctl.precharge_req = own && fb && b_swon && b_pre
                            && (r_q.seq == CCWD_PRECHG || r_q.seq == CCWD_IDLE);
    r_d.ctl.breaker_close_permit = own && fb && b_swon && b_brk;
    r_d.ctl.breaker_close_req = own && fb && b_swon && b_brk
                                && (r_q.seq == CCWD_CLOSE || r_q.seq == CCWD_RUN);
    r_d.ctl.breaker_open_req = own && fb && (!b_swon || !b_brk);
    r_d.ctl.run_req = start_ok && b_brk && r_q.seq == CCWD_RUN;
    r_d.ctl.quick_stop_act = fb && !b_qs_n;
    r_d.ctl.event_reset = fb && r_q.cmd[`CCWD_B_EVRST];
    r_d.status = `CCWD_STAT_RST;
    r_d.status[`CCWD_S_WDOG] = r_q.cmd[`CCWD_B_WDOG];
    r_d.status[`CCWD_S_FBCTL] = fb;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_q.cmd    <= `CCWD_CMD_RST;
      r_q.pd     <= `CCWD_PD_RST;
      r_q.seq    <= CCWD_IDLE;
      r_q.ctl    <= '0;
      r_q.status <= `CCWD_STAT_RST;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign ctl         = r_q.ctl;
  assign pd_out      = r_q.pd;
  assign status_word = r_q.status;
  assign remote_din  = r_q.cmd[`CCWD_B_DIN_HI:`CCWD_B_DIN_LO];

  genvar gi;
  generate
    for (gi = 0; gi < NFUNC; gi++) begin : g_fsel
      ccwd_src_sel u_sel (
        .din (remote_din),
        .sel (func_src_sel[gi*`CCWD_SEL_W +: `CCWD_SEL_W]),
        .act (func_act[gi])
      );
    end
  endgenerate

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_prechg_done;
    clk_en && start_ok && b_brk && r_q.seq == CCWD_PRECHG && precharge_done;
  endsequence
  sequence s_breaker_in;
    clk_en && start_ok && b_brk && r_q.seq == CCWD_CLOSE && breaker_closed;
  endsequence
  sequence s_start_idle;
    clk_en && start_ok && own && r_q.seq == CCWD_IDLE;
  endsequence

  AST_SWON_OFF: assert property (clk_en && fb && !b_swon |=> r_q.seq == CCWD_IDLE && !ctl.run_req
                                 && !ctl.precharge_req && (ctl.breaker_open_req == $past(own)))
    else $error("switch-on low did not block");
  AST_BRK_OFF: assert property (clk_en && !b_brk |=> !ctl.breaker_close_req && !ctl.run_req)
    else $error("breaker permit low did not block");
  AST_QSTOP: assert property (clk_en |=> ctl.quick_stop_act == $past(fb && !b_qs_n))
    else $error("quick stop mismatch");
  AST_STOP: assert property (clk_en && !b_start |=> r_q.seq == CCWD_IDLE ##1 !ctl.run_req || !$past(clk_en))
    else $error("start low did not stop");
  AST_SEQ_CLOSE: assert property (s_prechg_done |=> r_q.seq == CCWD_CLOSE)
    else $error("precharge done did not close breaker");
  AST_SEQ_RUN: assert property (s_breaker_in |=> r_q.seq == CCWD_RUN)
    else $error("breaker closed did not run");
  AST_PRECHG: assert property (clk_en && !b_pre |=> !ctl.precharge_req)
    else $error("precharge not stopped");
  AST_EVRST: assert property (clk_en |=> ctl.event_reset == $past(fb && r_q.cmd[`CCWD_B_EVRST]))
    else $error("event reset mismatch");
  AST_PD_HOLD: assert property (clk_en && cmd_wr && !cmd_word[`CCWD_B_DVALID] |=> $stable(pd_out))
    else $error("process data changed while invalid");
  AST_PD_TAKE: assert property (clk_en && cmd_wr && cmd_word[`CCWD_B_DVALID] |=> pd_out == $past(pd_in))
    else $error("valid process data not taken");
  AST_PLACE: assert property (clk_en && !fb |=> !ctl.run_req && !ctl.quick_stop_act
                              && !ctl.event_reset && !ctl.breaker_close_req)
    else $error("command honoured outside fieldbus control");
  AST_WDOG: assert property (clk_en && cmd_wr ##1 clk_en |=>
                             status_word[`CCWD_S_WDOG] == $past(cmd_word[`CCWD_B_WDOG], 2))
    else $error("watchdog echo wrong");
  AST_FBFLAG: assert property (clk_en |=> status_word[`CCWD_S_FBCTL] == $past(fb))
    else $error("control place flag wrong");
  // Clock enable low freezes every flop unless sys_rst is high
  AST_FREEZE: assert property (!clk_en |=> $stable(r_q))
    else $error("state moved while clock enable low");
  AST_NO_OWN: assert property (clk_en && !own |=> !ctl.precharge_req && !ctl.breaker_close_permit
                               && !ctl.breaker_close_req && !ctl.breaker_open_req)
    else $error("precharge or breaker driven without ownership");
  AST_DIN: assert property (clk_en && cmd_wr |=>
                            remote_din == $past(cmd_word[`CCWD_B_DIN_HI:`CCWD_B_DIN_LO]))
    else $error("remote inputs not taken");
  AST_WDOG_LVL: assert property (clk_en |=> status_word[`CCWD_S_WDOG] == $past(r_q.cmd[`CCWD_B_WDOG]))
    else $error("watchdog level wrong");
  AST_STAT_SPARE: assert property (clk_en |=> status_word[`CCWD_S_WDOG-1:`CCWD_S_FBCTL+1] == '0
                                   && status_word[`CCWD_S_FBCTL-1:0] == '0)
    else $error("unused status bits set");
  AST_OPEN: assert property (clk_en && own && fb && !b_brk |=> ctl.breaker_open_req)
    else $error("breaker not opened");
  AST_PERMIT: assert property (clk_en && own && fb && b_swon && b_brk |=> ctl.breaker_close_permit)
    else $error("breaker close not permitted");
  AST_SEQ_PRE: assert property (s_start_idle |=> r_q.seq == CCWD_PRECHG)
    else $error("start did not begin with precharge");
  AST_RUN_ONLY: assert property (clk_en && !(b_swon && b_qs_n && b_start && b_brk) |=> !ctl.run_req)
    else $error("running without all permits");
  AST_PRE_ON: assert property (clk_en && own && fb && b_swon && b_pre && r_q.seq == CCWD_PRECHG
                               |=> ctl.precharge_req)
    else $error("precharge not requested");
  AST_QS_IDLE: assert property (clk_en && !b_qs_n |=> r_q.seq == CCWD_IDLE)
    else $error("quick stop did not halt sequence");
endmodule : ccwd_decoder
`default_nettype wire

// [testbench/ccwd_fb_model.sv]
// Fieldbus controller model that writes command words
`timescale 1ns/1ps
`default_nettype none
module ccwd_fb_model (
  // Clock
  input  wire logic   core_clk,
  // Process data to the decoder
  output logic        cmd_wr,
  output logic [15:0] cmd_word,
  output logic [15:0] pd_in
);
  logic wd;
  initial begin
    wd = 1'b0;
    cmd_wr = 1'b0;
    cmd_word = 16'h0000;
    pd_in = 16'h0000;
  end
  // Sign-of-life toggles on every write
  task send(input logic [15:0] w, input logic [15:0] p);
    @(negedge core_clk);
    wd = ~wd;
    cmd_wr = 1'b1;
    cmd_word = {w[15:12], wd, w[10:0]};
    pd_in = p;
    @(negedge core_clk);
    cmd_wr = 1'b0;
    cmd_word = ~cmd_word;
    pd_in = ~pd_in;
  endtask : send
endmodule : ccwd_fb_model
`default_nettype wire

// [testbench/test_ccwd_decoder.sv]
// Testbench for the command word decoder
`timescale 1ns/1ps
`default_nettype none
module test_ccwd_decoder;
  import ccwd_pkg::*;
  logic        core_clk, sys_rst, clk_en, cmd_wr;
  logic        flag, own, done, closed;
  logic [15:0] cmd_word, pd_in, pd_out, status_word;
  logic [11:0] sel;
  logic [3:0]  remote_din, func_act;
  ccwd_ctl_t   ctl;
  int          n_mismatch, comparisons;

  ccwd_fb_model u_ccwd_fb_model (.core_clk(core_clk), .cmd_wr(cmd_wr),
    .cmd_word(cmd_word), .pd_in(pd_in));
  ccwd_decoder u_ccwd_decoder (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .cmd_wr(cmd_wr), .cmd_word(cmd_word), .pd_in(pd_in),
    .remote_control_place_flag(flag), .gcu_owns_breaker(own),
    .precharge_done(done), .breaker_closed(closed), .func_src_sel(sel),
    .ctl(ctl), .pd_out(pd_out), .status_word(status_word),
    .remote_din(remote_din), .func_act(func_act));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wt
  task chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task chkb(input logic s, input logic e);
    chk({15'h0, s}, {15'h0, e});
  endtask : chkb
  task wr(input logic [15:0] w, input logic [15:0] p);
    u_ccwd_fb_model.send(w, p);
    wt(3);
    chk(status_word, {u_ccwd_fb_model.wd, 5'h0, flag, 9'h0});
  endtask : wr

  task t_flag_low;
    flag = 1'b0;
    wr(16'h541f, 16'h1111);
    chk({9'h0, ctl}, 16'h0000);
    chk({12'h0, remote_din}, 16'h0005);
  endtask : t_flag_low
  task t_startup;
    flag = 1'b1;
    wr(16'h041f, 16'h1234);
    chkb(ctl.precharge_req, 1'b1);
    chkb(ctl.breaker_close_permit, 1'b1);
    chk(pd_out, 16'h1234);
    done = 1'b1;
    wt(4);
    chkb(ctl.breaker_close_req, 1'b1);
    chkb(ctl.run_req, 1'b0);
    closed = 1'b1;
    wt(4);
    chkb(ctl.run_req, 1'b1);
    wr(16'h0017, 16'hbeef);
    wt(1);
    chk(pd_out, 16'h1234);
    chkb(ctl.run_req, 1'b0);
  endtask : t_startup
  task t_permits;
    wr(16'h041f, 16'h0000);
    wt(4);
    wr(16'h041d, 16'h0000);
    chkb(ctl.breaker_close_permit, 1'b0);
    chkb(ctl.run_req, 1'b0);
    wr(16'h041f, 16'h0000);
    wt(4);
    wr(16'h041e, 16'h0000);
    chkb(ctl.run_req, 1'b0);
    chkb(ctl.breaker_open_req, 1'b1);
    chkb(ctl.precharge_req, 1'b0);
    wr(16'h040f, 16'h0000);
    chkb(ctl.precharge_req, 1'b0);
  endtask : t_permits
  task t_no_own;
    own = 1'b0;
    done = 1'b0;
    closed = 1'b0;
    wr(16'h0417, 16'h0000);
    wr(16'h041f, 16'h0000);
    wt(3);
    chkb(ctl.run_req, 1'b1);
    chkb(ctl.breaker_close_permit, 1'b0);
    chkb(ctl.breaker_open_req, 1'b0);
    own = 1'b1;
  endtask : t_no_own
  task t_bits;
    wr(16'h03e3, 16'h0000);
    chkb(ctl.quick_stop_act, 1'b1);
    chkb(ctl.event_reset, 1'b1);
    wr(16'h0364, 16'h0000);
    chkb(ctl.quick_stop_act, 1'b0);
    chkb(ctl.event_reset, 1'b0);
  endtask : t_bits
  task t_din;
    sel = {3'h4, 3'h3, 3'h2, 3'h1};
    wr(16'ha000, 16'h0000);
    chk({12'h0, remote_din}, 16'h000a);
    chk({12'h0, func_act}, 16'h000a);
    sel = {3'h5, 3'h0, 3'h4, 3'h2};
    wt(1);
    chk({12'h0, func_act}, 16'h0003);
  endtask : t_din
  task t_freeze_reset;
    clk_en = 1'b0;
    u_ccwd_fb_model.send(16'h5400, 16'h2222);
    wt(3);
    chk({12'h0, remote_din}, 16'h000a);
    chk(pd_out, 16'h0000);
    chk(status_word, 16'h8200);
    clk_en = 1'b1;
    sys_rst = 1'b1;
    wt(2);
    chk({9'h0, ctl}, 16'h0000);
    chk(status_word, 16'h0000);
    chk({12'h0, remote_din}, 16'h0000);
    sys_rst = 1'b0;
    wr(16'h0000, 16'h0000);
    chkb(ctl.quick_stop_act, 1'b1);
    chkb(ctl.breaker_open_req, 1'b1);
  endtask : t_freeze_reset

  task complete_run;
    $display("n_mismatch=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  initial begin
    #20000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    {sys_rst, clk_en, flag, own, done, closed} = 6'b110100;
    sel = 12'h000;
    wt(6);
    sys_rst = 1'b0;
    t_flag_low();
    t_startup();
    t_permits();
    t_no_own();
    t_bits();
    t_din();
    t_freeze_reset();
    complete_run();
  end
endmodule : test_ccwd_decoder
`default_nettype wire
